// ---- ledfm_defs.vh ----
// constants for the led driver fault monitor
`ifndef LEDFM_DEFS_VH
`define LEDFM_DEFS_VH

`define LEDFM_CLK_HZ 20000000
`define LEDFM_GND_QUAL_MS 20
`define LEDFM_GND_PROBE_US 300
`define LEDFM_BUS_TMO_MS 500
`define LEDFM_RECOVER_MS 100

// register byte offsets
`define LEDFM_A_BOOST_STAT 8'h00
`define LEDFM_A_LED_STAT 8'h04
`define LEDFM_A_CUR_CODE 8'h08
`define LEDFM_A_CTRL 8'h0C
`define LEDFM_A_CONFIG 8'h10

// boost fault status fields
`define LEDFM_B_STRCFG 0
`define LEDFM_B_MODE 1
`define LEDFM_B_FREQ 2
`define LEDFM_B_CURSET 3
`define LEDFM_B_OTEMP 4
// string_fault_flags fields
`define LEDFM_L_SUMMARY 0
`define LEDFM_L_OPEN 1
`define LEDFM_L_SHORT 2
`define LEDFM_L_GND 3
`define LEDFM_L_UNUSED 4
`define LEDFM_L_BUSERR 5
`define LEDFM_L_CHAN 8
// control fields
`define LEDFM_C_LED_IE 0
`define LEDFM_C_FLT_IE 1

// reset and fallback values
`define LEDFM_CODE_RST 12'hFFF
`define LEDFM_CTRL_RST 2'h3
`define LEDFM_CFG_DFLT 3'h7
`define LEDFM_ADDR_DFLT 7'h2A
`define LEDFM_FBST_DFLT 4'h0
`define LEDFM_FDIM_DFLT 4'h0
`define LEDFM_NCH 6

`endif

// ---- ledfm_gnd.v ----
// per-channel ground-short qualify and probe sequencer
`timescale 1ns/10ps
module ledfm_gnd #(
  parameter QUAL_CYC = 400000,
  parameter PROBE_CYC = 6000,
  parameter CW = 20
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // monitor
  input wire active,
  input wire below_gnd,
  input wire below_hr,
  // results
  output reg probe_q,
  output reg report_q
);
  localparam S_IDLE = 2'd0;
  localparam S_QUAL = 2'd1;
  localparam S_PROBE = 2'd2;
  reg [1:0] st_q;
  reg [CW-1:0] cnt_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= S_IDLE;
      cnt_q <= {CW{1'b0}};
      probe_q <= 1'b0;
      report_q <= 1'b0;
    end else begin
      report_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          cnt_q <= {CW{1'b0}};
          if (active && below_gnd)
            st_q <= S_QUAL;
        end
        S_QUAL: begin
          if (!active || !below_gnd) begin
            st_q <= S_IDLE;
          end else if (cnt_q == QUAL_CYC[CW-1:0] - 1'b1) begin
            st_q <= S_PROBE;
            probe_q <= 1'b1;
            cnt_q <= {CW{1'b0}};
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        S_PROBE: begin
          if (cnt_q == PROBE_CYC[CW-1:0] - 1'b1) begin
            probe_q <= 1'b0;
            report_q <= below_hr;
            st_q <= S_IDLE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule

// ---- ledfm_top.v ----
// led driver fault monitor with ahb-lite status registers
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/10ps
`include "ledfm_defs.vh"
module ledfm_top #(
  parameter NCH = `LEDFM_NCH,
  parameter GND_QUAL_CYC = `LEDFM_GND_QUAL_MS * (`LEDFM_CLK_HZ / 1000),
  parameter GND_PROBE_CYC =
    `LEDFM_GND_PROBE_US * (`LEDFM_CLK_HZ / 1000000),
  parameter BUS_TMO_CYC = `LEDFM_BUS_TMO_MS * (`LEDFM_CLK_HZ / 1000),
  parameter RECOVER_CYC = `LEDFM_RECOVER_MS * (`LEDFM_CLK_HZ / 1000)
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // setting resistor sense, valid at initialization
  input wire string_config_resistor_ok,
  input wire [2:0] string_config_resistor,
  input wire mode_resistor_ok,
  input wire mode_pwm_sel,
  input wire [6:0] mode_bus_addr,
  input wire converter_freq_resistor_ok,
  input wire [3:0] converter_freq_resistor,
  input wire dimming_freq_resistor_ok,
  input wire [3:0] dimming_freq_resistor,
  input wire [5:0] unused_output_grounded,
  // analog comparators
  input wire current_set_pin_low,
  input wire overtemp_hot,
  input wire overtemp_cool,
  input wire boost_run_phase,
  input wire boost_at_max,
  input wire boost_at_min,
  input wire grouped_few,
  input wire [5:0] below_headroom,
  input wire [5:0] above_headroom_hys,
  input wire [5:0] above_short_level,
  input wire [5:0] in_normal_window,
  input wire [5:0] below_ground_level,
  // serial command block
  input wire serial_busy,
  output reg serial_reset,
  // latched configuration
  output reg [2:0] string_cfg,
  output reg pwm_phase_mode,
  output reg [6:0] bus_addr,
  output reg [3:0] boost_freq_sel,
  output reg [3:0] dim_freq_sel,
  // power and channel control
  output reg [11:0] channel_current_code,
  output reg boost_en,
  output reg powerline_en,
  output reg raise_boost,
  output reg [5:0] led_en,
  output reg [5:0] adaptive_en,
  output reg [5:0] probe_6ma,
  output reg irq
);
  localparam TW = 24;

  // channels in use for a configuration code
  function [5:0] used_mask;
    input [2:0] cfg;
    begin
      case (cfg)
        3'h0: used_mask = 6'h01;
        3'h1: used_mask = 6'h03;
        3'h2: used_mask = 6'h07;
        3'h3: used_mask = 6'h0F;
        3'h4: used_mask = 6'h1F;
        default: used_mask = 6'h3F;
      endcase
    end
  endfunction

  function [2:0] reg_idx;
    input [7:0] a;
    begin
      case (a)
        `LEDFM_A_BOOST_STAT: reg_idx = 3'd1;
        `LEDFM_A_LED_STAT: reg_idx = 3'd2;
        `LEDFM_A_CUR_CODE: reg_idx = 3'd3;
        `LEDFM_A_CTRL: reg_idx = 3'd4;
        `LEDFM_A_CONFIG: reg_idx = 3'd5;
        default: reg_idx = 3'd0;
      endcase
    end
  endfunction

  reg init_q;
  reg [4:0] bstat_q;
  reg [5:0] lstat_q;
  reg [5:0] chan_flt_q;
  reg [5:0] chan_off_q;
  reg [11:0] prog_code_q;
  reg [1:0] ctrl_q;
  reg ot_shut_q;
  reg current_set_pin_prev_q;
  reg ot_prev_q;
  reg recover_q;
  reg [TW-1:0] rec_cnt_q;
  reg [TW-1:0] tmo_cnt_q;
  reg tmo_done_q;
  reg wr_pend_q;
  reg [2:0] wr_idx_q;
  wire [5:0] gnd_probe;
  wire [5:0] gnd_report;

  wire [5:0] used = used_mask(string_cfg);
  wire [5:0] live = used & ~chan_off_q;
  wire run = !init_q && !ot_shut_q && !recover_q;
  wire [5:0] open_evt = {6{boost_en & boost_at_max}} & live &
    below_headroom;
  wire normal_any = |(live & in_normal_window);
  wire [5:0] short_evt = {6{boost_en}} & live &
    (({6{normal_any}} & above_short_level) |
    ({6{grouped_few & boost_at_min}} & above_headroom_hys));
  wire [5:0] unused_evt = {6{init_q}} & ~used_mask(string_config_resistor_ok
    ? string_config_resistor : `LEDFM_CFG_DFLT) & ~unused_output_grounded;
  wire gnd_evt = |gnd_report;
  wire led_evt = |open_evt || |short_evt || gnd_evt;
  wire tmo_hit = serial_busy && !tmo_done_q &&
    tmo_cnt_q == BUS_TMO_CYC[TW-1:0] - 1'b1;
  wire current_set_pin_rise = current_set_pin_low && !current_set_pin_prev_q;
  wire ot_rise = ot_shut_q && !ot_prev_q;

  // ahb write data phase
  wire wr_b = wr_pend_q && wr_idx_q == 3'd1;
  wire wr_l = wr_pend_q && wr_idx_q == 3'd2;
  wire clr_sum = wr_l && hwdata[`LEDFM_L_SUMMARY];
  wire clr_unu = wr_l && hwdata[`LEDFM_L_UNUSED];
  wire clr_bus = wr_l && hwdata[`LEDFM_L_BUSERR];
  wire clr_cur = wr_b && hwdata[`LEDFM_B_CURSET];
  wire clr_ot = wr_b && hwdata[`LEDFM_B_OTEMP];
  wire addr_ok = hsel && htrans[1] && hready;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gch
      ledfm_gnd #(
        .QUAL_CYC(GND_QUAL_CYC),
        .PROBE_CYC(GND_PROBE_CYC),
        .CW(20)
      ) u_gnd (
        .hclk(hclk),
        .hresetn(hresetn),
        .active(boost_run_phase && run && live[g]),
        .below_gnd(below_ground_level[g]),
        .below_hr(below_headroom[g]),
        .probe_q(gnd_probe[g]),
        .report_q(gnd_report[g])
      );
    end
  endgenerate

  // bus slave
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_idx_q <= 3'd0;
    end else begin
      hreadyout <= 1'b1;
      wr_pend_q <= addr_ok && hwrite;
      wr_idx_q <= reg_idx(haddr);
      if (addr_ok && !hwrite) begin
        case (reg_idx(haddr))
          3'd1: hrdata <= {27'h000_0000, bstat_q};
          3'd2: hrdata <= {18'h0_0000, chan_flt_q, 2'b00, lstat_q};
          3'd3: hrdata <= {20'h0_0000, prog_code_q};
          3'd4: hrdata <= {30'h0000_0000, ctrl_q};
          3'd5: hrdata <= {13'h0000, dim_freq_sel, boost_freq_sel,
            bus_addr, pwm_phase_mode, string_cfg};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // settings captured once at release of reset, never rechecked
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_q <= 1'b1;
      string_cfg <= `LEDFM_CFG_DFLT;
      pwm_phase_mode <= 1'b1;
      bus_addr <= `LEDFM_ADDR_DFLT;
      boost_freq_sel <= `LEDFM_FBST_DFLT;
      dim_freq_sel <= `LEDFM_FDIM_DFLT;
    end else if (init_q) begin
      init_q <= 1'b0;
      string_cfg <= string_config_resistor_ok ? string_config_resistor
        : `LEDFM_CFG_DFLT;
      pwm_phase_mode <= mode_resistor_ok ? mode_pwm_sel : 1'b1;
      bus_addr <= mode_resistor_ok ? mode_bus_addr
        : `LEDFM_ADDR_DFLT;
      boost_freq_sel <= converter_freq_resistor_ok ?
        converter_freq_resistor : `LEDFM_FBST_DFLT;
      dim_freq_sel <= dimming_freq_resistor_ok ?
        dimming_freq_resistor : `LEDFM_FDIM_DFLT;
    end
  end

  // status flags; a new event beats a same-cycle clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bstat_q <= 5'h00;
      lstat_q <= 6'h00;
      chan_flt_q <= 6'h00;
      chan_off_q <= 6'h00;
      current_set_pin_prev_q <= 1'b0;
      ot_prev_q <= 1'b0;
    end else begin
      current_set_pin_prev_q <= current_set_pin_low;
      ot_prev_q <= ot_shut_q;
      if (init_q) begin
        bstat_q[`LEDFM_B_STRCFG] <= !string_config_resistor_ok;
        bstat_q[`LEDFM_B_MODE] <= !mode_resistor_ok;
        bstat_q[`LEDFM_B_FREQ] <= !converter_freq_resistor_ok ||
          !dimming_freq_resistor_ok;
      end
      bstat_q[`LEDFM_B_CURSET] <= current_set_pin_rise ||
        (bstat_q[`LEDFM_B_CURSET] && !clr_cur);
      bstat_q[`LEDFM_B_OTEMP] <= ot_rise ||
        (bstat_q[`LEDFM_B_OTEMP] && !clr_ot);
      lstat_q[`LEDFM_L_SUMMARY] <= led_evt ||
        (lstat_q[`LEDFM_L_SUMMARY] && !clr_sum);
      lstat_q[`LEDFM_L_UNUSED] <= |unused_evt ||
        (lstat_q[`LEDFM_L_UNUSED] && !clr_unu);
      lstat_q[`LEDFM_L_BUSERR] <= tmo_hit ||
        (lstat_q[`LEDFM_L_BUSERR] && !clr_bus);
      // detail bits hold until reset
      if (|open_evt)
        lstat_q[`LEDFM_L_OPEN] <= 1'b1;
      if (|short_evt)
        lstat_q[`LEDFM_L_SHORT] <= 1'b1;
      if (gnd_evt)
        lstat_q[`LEDFM_L_GND] <= 1'b1;
      chan_flt_q <= chan_flt_q | open_evt | short_evt |
        gnd_report;
      chan_off_q <= chan_off_q | open_evt | short_evt;
    end
  end

  // thermal shutdown with hysteresis
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      ot_shut_q <= 1'b0;
    else if (overtemp_hot)
      ot_shut_q <= 1'b1;
    else if (overtemp_cool)
      ot_shut_q <= 1'b0;
  end

  // fault recovery timed from the ground-short report
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      recover_q <= 1'b0;
      rec_cnt_q <= {TW{1'b0}};
    end else if (gnd_evt) begin
      recover_q <= 1'b1;
      rec_cnt_q <= {TW{1'b0}};
    end else if (recover_q) begin
      if (rec_cnt_q == RECOVER_CYC[TW-1:0] - 1'b1)
        recover_q <= 1'b0;
      else
        rec_cnt_q <= rec_cnt_q + 1'b1;
    end
  end

  // serial stop timeout; one reset per stuck transaction
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmo_cnt_q <= {TW{1'b0}};
      tmo_done_q <= 1'b0;
      serial_reset <= 1'b0;
    end else begin
      serial_reset <= tmo_hit;
      if (!serial_busy) begin
        tmo_cnt_q <= {TW{1'b0}};
        tmo_done_q <= 1'b0;
      end else if (tmo_hit) begin
        tmo_done_q <= 1'b1;
      end else if (!tmo_done_q) begin
        tmo_cnt_q <= tmo_cnt_q + 1'b1;
      end
    end
  end

  // programmed current and control registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_code_q <= `LEDFM_CODE_RST;
      ctrl_q <= `LEDFM_CTRL_RST;
    end else if (wr_pend_q) begin
      if (wr_idx_q == 3'd3)
        prog_code_q <= hwdata[11:0];
      if (wr_idx_q == 3'd4)
        ctrl_q <= hwdata[1:0];
    end
  end

  // outputs, all from flops
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_current_code <= `LEDFM_CODE_RST;
      boost_en <= 1'b0;
      powerline_en <= 1'b0;
      raise_boost <= 1'b0;
      led_en <= 6'h00;
      adaptive_en <= 6'h00;
      probe_6ma <= 6'h00;
      irq <= 1'b0;
    end else begin
      channel_current_code <= current_set_pin_low ?
        {2'b00, prog_code_q[11:2]} : prog_code_q;
      boost_en <= run && !gnd_evt;
      powerline_en <= run && !gnd_evt;
      raise_boost <= run && |(live & below_headroom);
      led_en <= {6{run && !gnd_evt}} & live & ~gnd_probe;
      adaptive_en <= live;
      probe_6ma <= gnd_probe;
      irq <= (ctrl_q[`LEDFM_C_LED_IE] && (lstat_q[`LEDFM_L_SUMMARY] ||
        led_evt)) || (ctrl_q[`LEDFM_C_FLT_IE] &&
        (bstat_q[`LEDFM_B_CURSET] || bstat_q[`LEDFM_B_OTEMP] ||
        lstat_q[`LEDFM_L_UNUSED] || lstat_q[`LEDFM_L_BUSERR]));
    end
  end

endmodule

// ---- ledfm_monitor.sv ----
// assertion checker for the led driver fault monitor
`timescale 1ns/10ps
module ledfm_monitor #(
  parameter BUS_TMO_CYC = 30
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // watched inputs
  input wire current_set_pin_low,
  input wire overtemp_hot,
  input wire serial_busy,
  input wire boost_run_phase,
  input wire boost_at_max,
  input wire [5:0] below_headroom,
  input wire [5:0] above_short_level,
  input wire [5:0] in_normal_window,
  // watched outputs
  input wire serial_reset,
  input wire [2:0] string_cfg,
  input wire pwm_phase_mode,
  input wire [6:0] bus_addr,
  input wire [3:0] boost_freq_sel,
  input wire [3:0] dim_freq_sel,
  input wire [11:0] channel_current_code,
  input wire boost_en,
  input wire powerline_en,
  input wire [5:0] led_en,
  input wire [5:0] adaptive_en
);
  reg [1:0] init_q;
  reg [31:0] busy_q;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // init_q saturates once the capture edges are well past
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_q <= 2'd0;
      busy_q <= 32'd0;
    end else begin
      init_q <= (init_q == 2'd3) ? init_q : init_q + 2'd1;
      busy_q <= serial_busy ? busy_q + 32'd1 : 32'd0;
    end
  end
  property p_cfg_frozen;
    init_q == 2'd3 |-> $stable(string_cfg);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen)
    else $error("string config moved after init");
  property p_mode_frozen;
    init_q == 2'd3 |-> $stable({pwm_phase_mode, bus_addr});
  endproperty
  a_mode_frozen: assert property (p_mode_frozen)
    else $error("mode or address moved after init");
  property p_freq_frozen;
    init_q == 2'd3 |-> $stable({boost_freq_sel, dim_freq_sel});
  endproperty
  a_freq_frozen: assert property (p_freq_frozen)
    else $error("frequency select moved after init");
  property p_quarter;
    current_set_pin_low [*3] |-> channel_current_code[11:10] == 2'b00;
  endproperty
  a_quarter: assert property (p_quarter)
    else $error("current code not reduced");
  property p_overtemp;
    overtemp_hot ##1 overtemp_hot |-> ##1 (!boost_en && !powerline_en
      && led_en == 6'h00);
  endproperty
  a_overtemp: assert property (p_overtemp)
    else $error("outputs on while hot");
  property p_open;
    boost_run_phase && boost_at_max && below_headroom[0] && led_en[0]
      |-> ##[1:3] !led_en[0] && !adaptive_en[0];
  endproperty
  a_open: assert property (p_open)
    else $error("open string left enabled");
  property p_short;
    above_short_level[1] && (|in_normal_window)
      |-> ##[1:3] !led_en[1] && !adaptive_en[1];
  endproperty
  a_short: assert property (p_short)
    else $error("shorted string left enabled");
  property p_bus_tmo;
    busy_q == BUS_TMO_CYC - 1 |-> ##[0:3] serial_reset;
  endproperty
  a_bus_tmo: assert property (p_bus_tmo)
    else $error("no serial reset after timeout");
  property p_bus_pulse;
    serial_reset |-> busy_q >= BUS_TMO_CYC - 3 ##1 !serial_reset;
  endproperty
  a_bus_pulse: assert property (p_bus_pulse)
    else $error("serial reset early or too long");
  c_tmo: cover property (serial_reset);
  c_shut: cover property ($fell(boost_en));
  c_cur: cover property (current_set_pin_low ##3 current_set_pin_low);
endmodule

bind ledfm_top ledfm_monitor #(.BUS_TMO_CYC(BUS_TMO_CYC)) u_mon (
  .hclk, .hresetn, .current_set_pin_low, .overtemp_hot, .serial_busy,
  .boost_run_phase, .boost_at_max, .below_headroom, .above_short_level,
  .in_normal_window, .serial_reset, .string_cfg, .pwm_phase_mode,
  .bus_addr, .boost_freq_sel, .dim_freq_sel, .channel_current_code,
  .boost_en, .powerline_en, .led_en, .adaptive_en
);

// ---- ledfm_strings.sv ----
// behavioural led strings and sink comparators
`timescale 1ns/10ps
module ledfm_strings (
  // clock
  input wire hclk,
  // sink controls
  input wire [5:0] led_en,
  input wire [5:0] probe_6ma,
  // per channel: 0 good, 1 open, 2 short, 3 to ground
  input wire [11:0] fault_mode,
  // comparator levels
  output reg [5:0] below_headroom = 6'h00,
  output reg [5:0] above_headroom_hys = 6'h00,
  output reg [5:0] above_short_level = 6'h00,
  output reg [5:0] in_normal_window = 6'h00,
  output reg [5:0] below_ground_level = 6'h00
);
  integer i;
  reg [1:0] m;
  reg on;
  always @(posedge hclk) begin
    for (i = 0; i < 6; i = i + 1) begin
      m = fault_mode[2*i +: 2];
      on = led_en[i] | probe_6ma[i];
      // an idle sink floats to the rail, so it shows no error
      below_headroom[i] <= on & (m == 2'd1 || m == 2'd3);
      above_headroom_hys[i] <= on & (m == 2'd2);
      above_short_level[i] <= on & (m == 2'd2);
      in_normal_window[i] <= on & (m == 2'd0);
      // a grounded string stays low with the sink off
      below_ground_level[i] <= (m == 2'd3);
    end
  end
endmodule

// ---- ledfm_tb_top.sv ----
// self-checking bench for the led driver fault monitor
`timescale 1ns/10ps
module ledfm_tb_top;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hsel = 1'b0;
  reg [7:0] haddr = 8'h00;
  reg [1:0] htrans = 2'b00;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0000_0000;
  reg sok = 1'b0, mok = 1'b0, cok = 1'b0, dok = 1'b0, psel = 1'b0;
  reg [2:0] scr = 3'h0;
  reg [6:0] madr = 7'h00;
  reg [3:0] cf = 4'h0, df = 4'h0;
  reg [5:0] ugnd = 6'h00;
  reg cs_low = 1'b0, hot = 1'b0, cool = 1'b0, run = 1'b0, at_max = 1'b0;
  reg serial_busy = 1'b0, at_min = 1'b0, grp = 1'b0;
  reg [11:0] fmode = 12'h000;
  wire [31:0] hrdata;
  wire hreadyout, hresp, serial_reset, pwm_phase_mode, boost_en;
  wire powerline_en, irq, raise_boost;
  wire [2:0] string_cfg;
  wire [6:0] bus_addr;
  wire [3:0] boost_freq_sel, dim_freq_sel;
  wire [11:0] channel_current_code;
  wire [5:0] led_en, adaptive_en, probe_6ma, bh, bhh, asl, inw, bgl;
  integer fails = 0, n_compared = 0, seed = 32'h0bf8, n;
  reg [31:0] rd, v;
  always #25 hclk = ~hclk;
  ledfm_top #(.GND_QUAL_CYC(20), .GND_PROBE_CYC(5), .BUS_TMO_CYC(30),
    .RECOVER_CYC(25)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .string_config_resistor_ok(sok),
    .string_config_resistor(scr), .mode_resistor_ok(mok),
    .mode_pwm_sel(psel), .mode_bus_addr(madr),
    .converter_freq_resistor_ok(cok), .converter_freq_resistor(cf),
    .dimming_freq_resistor_ok(dok), .dimming_freq_resistor(df),
    .unused_output_grounded(ugnd), .current_set_pin_low(cs_low),
    .overtemp_hot(hot), .overtemp_cool(cool), .boost_run_phase(run),
    .boost_at_max(at_max), .boost_at_min(at_min), .grouped_few(grp),
    .below_headroom(bh), .above_headroom_hys(bhh),
    .above_short_level(asl), .in_normal_window(inw),
    .below_ground_level(bgl), .serial_busy, .serial_reset, .string_cfg,
    .pwm_phase_mode, .bus_addr, .boost_freq_sel, .dim_freq_sel,
    .channel_current_code, .boost_en, .powerline_en, .raise_boost,
    .led_en, .adaptive_en, .probe_6ma, .irq);
  ledfm_strings u_str (.hclk, .led_en, .probe_6ma, .fault_mode(fmode),
    .below_headroom(bh), .above_headroom_hys(bhh),
    .above_short_level(asl), .in_normal_window(inw),
    .below_ground_level(bgl));
  task chk(input [31:0] s, input [31:0] e);
    begin
      n_compared = n_compared + 1;
      if (s !== e) begin
        fails = fails + 1;
        $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // waits until sig matches x, bounded
  task wait_on(input sel, input x);
    begin
      n = 0;
      while ((sel ? boost_en : hreadyout) !== x) begin
        n = n + 1;
        if (n > 300) begin
          fails = fails + 1;
          tally_and_finish;
        end
        @(posedge hclk);
      end
    end
  endtask
  task bus(input [7:0] a, input w, input [31:0] wd);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      wait_on(0, 1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      wait_on(0, 1);
      rd = hrdata;
    end
  endtask
  task rchk(input [7:0] a, input [31:0] m, input [31:0] e);
    begin
      bus(a, 1'b0, 32'h0000_0000);
      chk(rd & m, e);
      chk(32'(hresp), 32'h0);
    end
  endtask
  function [31:0] ecfg(input ok);
    ecfg = ok ? {13'd0, df, cf, madr, psel, 3'd1} : 32'h0000_02AF;
  endfunction
  task do_reset(input ok);
    begin
      hresetn <= 1'b0;
      v = $random(seed);
      {sok, mok, cok, dok} <= {4{ok}};
      scr <= ok ? 3'd1 : v[2:0];
      {psel, madr, cf, df} <= v[19:4];
      ugnd <= 6'b00_0011;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
    end
  endtask
  initial begin
    do_reset(0);
    rchk(8'h00, 32'h7, 32'h7);
    chk(32'({dim_freq_sel, boost_freq_sel, bus_addr, pwm_phase_mode,
      string_cfg}), ecfg(0));
    rchk(8'h10, 32'hFFFF_FFFF, ecfg(0));
    {sok, mok, cok, dok, scr} <= 7'h7A;
    repeat (5) @(posedge hclk);
    rchk(8'h10, 32'hFFFF_FFFF, ecfg(0));
    cs_low <= 1'b1;
    repeat (3) @(posedge hclk);
    chk(32'(channel_current_code), 32'h3FF);
    cs_low <= 1'b0;
    v = $random(seed);
    bus(8'h08, 1'b1, v);
    cs_low <= 1'b1;
    repeat (3) @(posedge hclk);
    chk(32'(channel_current_code), 32'(v[11:2]));
    rchk(8'h00, 32'h8, 32'h8);
    chk(32'(irq), 32'h1);
    cs_low <= 1'b0;
    repeat (3) @(posedge hclk);
    chk(32'(channel_current_code), 32'(v[11:0]));
    $display("init and current tests done");
    run <= 1'b1;
    wait_on(1, 1);
    hot <= 1'b1;
    repeat (3) @(posedge hclk);
    chk(32'({boost_en, powerline_en, led_en}), 32'h0);
    rchk(8'h00, 32'h10, 32'h10);
    hot <= 1'b0;
    cool <= 1'b1;
    wait_on(1, 1);
    chk(32'(powerline_en), 32'h1);
    cool <= 1'b0;
    repeat (10) @(posedge hclk);
    fmode <= 12'h001;
    at_max <= 1'b1;
    repeat (6) @(posedge hclk);
    chk(32'({led_en[0], adaptive_en[0]}), 32'h0);
    rchk(8'h04, 32'h103, 32'h103);
    bus(8'h04, 1'b1, 32'h1);
    rchk(8'h04, 32'h103, 32'h102);
    at_max <= 1'b0;
    // channel 1 shorted; channel 2 low but boost not at max: only a raise request
    fmode <= 12'h018;
    repeat (6) @(posedge hclk);
    chk(32'({led_en[1], adaptive_en[1]}), 32'h0);
    chk(32'(raise_boost), 32'h1);
    rchk(8'h04, 32'h205, 32'h205);
    fmode <= 12'h030;
    repeat (25) @(posedge hclk);
    chk(32'(probe_6ma), 32'h4);
    wait_on(1, 0);
    fmode <= 12'h000;
    chk(32'(powerline_en), 32'h0);
    rchk(8'h04, 32'h409, 32'h409);
    wait_on(1, 1);
    chk(32'(n > 10 && n < 40), 32'h1);
    $display("fault tests done");
    serial_busy <= 1'b1;
    v = 0;
    repeat (35) begin
      @(posedge hclk);
      v = v + 32'(serial_reset === 1'b1);
    end
    serial_busy <= 1'b0;
    chk(v, 32'h1);
    rchk(8'h04, 32'h20, 32'h20);
    bus(8'h0C, 1'b1, 32'h0);
    repeat (2) @(posedge hclk);
    chk(32'(irq), 32'h0);
    bus(8'h0C, 1'b1, 32'h3);
    repeat (2) @(posedge hclk);
    chk(32'(irq), 32'h1);
    bus(8'h00, 1'b1, 32'h18);
    bus(8'h04, 1'b1, 32'h31);
    repeat (2) @(posedge hclk);
    chk(32'(irq), 32'h0);
    rchk(8'h04, 32'h70E, 32'h70E);
    bus(8'h20, 1'b1, 32'hFFFF_FFFF);
    rchk(8'h20, 32'hFFFF_FFFF, 32'h0);
    bus(8'h10, 1'b1, 32'h0);
    rchk(8'h10, 32'hFFFF_FFFF, ecfg(0));
    $display("bus tests done");
    do_reset(1);
    rchk(8'h00, 32'h7, 32'h0);
    rchk(8'h10, 32'hFFFF_FFFF, ecfg(1));
    rchk(8'h04, 32'h10, 32'h10);
    chk(32'(irq), 32'h1);
    // both used strings high, none in the normal window
    fmode <= 12'h00A;
    repeat (6) @(posedge hclk);
    rchk(8'h04, 32'h4, 32'h0);
    at_min <= 1'b1;
    grp <= 1'b1;
    repeat (6) @(posedge hclk);
    chk(32'({led_en[1:0], adaptive_en[1:0]}), 32'h0);
    rchk(8'h04, 32'h304, 32'h304);
    $display("wiring test done");
    tally_and_finish;
  end
endmodule
